// >>> wesr_pkg.sv
// Package of the wake event status router: register map, field positions, reset values.
// Assumes a single 50 MHz core clock and a plain strobe register port.
package wesr_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_HOST_STATUS = 4'h0;
  localparam logic [3:0] ADDR_HOST_ROUTE_PWR = 4'h1;
  localparam logic [3:0] ADDR_HOST_ROUTE_SMI = 4'h2;
  localparam logic [3:0] ADDR_HOST_ROUTE_IRQ = 4'h3;
  localparam logic [3:0] ADDR_CORE_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CORE_ROUTE = 4'h5;
  localparam logic [3:0] ADDR_CONTROL1 = 4'h6;
  localparam logic [3:0] ADDR_DEV_WAKE_EN = 4'h7;
  localparam logic [3:0] ADDR_PIN_LEVELS = 4'h8;

  // ---------------------------------------------------------------------------
  // Field positions in the event status, control and device wake enable bytes
  // ---------------------------------------------------------------------------
  localparam int EV_SW = 0;
  localparam int EV_RING1 = 1;
  localparam int EV_RING2 = 2;
  localparam int EV_MOD_IRQ = 7;
  localparam int EV_W = 8;
  localparam int CTL_SW_CORE_MODE = 0;
  localparam int DEV_IRQ_WAKE_BIT = 4;
  localparam logic [7:0] DEV_IRQ_CFG_INDEX = 8'h70;

  // ---------------------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [EV_W-1:0] EV_RST = 8'h00;
  localparam logic [EV_W-1:0] EV_IMPL = 8'h87;
  localparam logic [7:0] CTL_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic power_up_request;
    logic smi;
    logic host_irq;
    logic core_wake_interrupt;
  } wesr_out_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wesr_bus_t;

endpackage

// >>> wesr_sync_edge.sv
// Two-flop synchroniser followed by a falling or rising edge detector.
// Assumes the input is asynchronous and the clock runs freely while detecting.
`timescale 1ns/1ps
module wesr_sync_edge #(
  parameter bit FALLING = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Signal
  input wire logic async_i,
  output logic edge_o
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = async_i;
    next_sync = meta;
    next_prev = sync;
  end

  // Reset level is the idle level so no edge is seen at release.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= FALLING;
      sync <= FALLING;
      prev <= FALLING;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign edge_o = FALLING ? (prev & ~sync) : (~prev & sync); // RULE21

endmodule // wesr_sync_edge

// >>> wesr_irq_combine.sv
// Combines logical-device interrupts gated by their wake-on-interrupt enables.
// Assumes device interrupts are active high and asynchronous.
`timescale 1ns/1ps
module wesr_irq_combine #(
  parameter int N_DEV = 3
) (
  // Device interrupts
  input wire logic [N_DEV-1:0] dev_irq_i,
  input wire logic [N_DEV-1:0] dev_wake_en_i,
  // Combined level
  output logic irq_any_o
);
  assign irq_any_o = |(dev_irq_i & dev_wake_en_i); // RULE12

endmodule // wesr_irq_combine

// >>> wesr_wake_controller.sv
// Functional notes
// (RULE1) Any detected event sets its host and core status bits, ignoring routing.
// (RULE2) Output asserts while an event's status and its routing enable are both set.
// (RULE3) Writing 1 clears a status bit; writing 0 leaves it.
// (RULE4) Clearing a routing enable stops the output but keeps the status bit.
// (RULE5) The core has its own mask selecting which status bits it answers.
// (RULE6) Software event is active per side while that side's status bit is set.
// (RULE7) Writing 1 to clear host software bit sets it; writing 1 when set clears.
// (RULE8) Host reaches host status only with main power; core always can.
// (RULE9) Core mode 0: core bit sets on host 0-to-1; mode 1: any write 1.
// (RULE10) Core software status clears by writing 1, independent of host bit.
// (RULE11) Module interrupt wake event is taken on the leading edge only.
// (RULE12) Per-device wake-on-interrupt enable; event is the OR of enabled interrupts.
// (RULE13) Module interrupt event sets bit 7; power-up request held till cleared.
// (RULE14) Falling edges on either modem ring input are wake events.
// (RULE15) Four outputs: power-up request, SMI, host interrupt, core interrupt.
// (RULE16) Clocked detection is inactive while the core clock is stopped.
// (RULE17) Software should handle each wake source in exactly one handler.
// (RULE18) Three host routing enable sets steer to power-up, SMI and interrupt.
// (RULE19) Outputs stay active until all feeding status bits are cleared or masked.
// (RULE20) Core wake interrupt is level high gathering enabled core status bits.
// (RULE21) Asynchronous inputs are synchronised before edge detection.
//
// Top of the wake controller: status, routing and outputs.
// Assumes one 50 MHz clock, a synchronous strobe register port and async event pins.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module wesr_wake_controller #(
  parameter int N_DEV = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_host_i,
  output logic [7:0] reg_rdata_o,
  // Power
  input wire logic main_pwr_i,
  // Event inputs
  input wire logic modem_ring_in1_n_i,
  input wire logic modem_ring_in2_n_i,
  input wire logic [N_DEV-1:0] dev_irq_i,
  // Output events
  output logic power_up_request_o,
  output logic smi_o,
  output logic host_irq_o,
  output logic core_wake_interrupt_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0] host_wake_status0;
  logic [7:0] core_wake_status0;
  logic [7:0] host_wake_route_pwr;
  logic [7:0] host_wake_route_smi;
  logic [7:0] host_wake_route_irq;
  logic [7:0] core_wake_route_enable;
  logic [7:0] wake_control1;
  logic [N_DEV-1:0] dev_wake_en;
  logic [7:0] rdata;
  wesr_pkg::wesr_out_t outs;

  logic [7:0] next_host_wake_status0;
  logic [7:0] next_core_wake_status0;
  logic [7:0] next_host_wake_route_pwr;
  logic [7:0] next_host_wake_route_smi;
  logic [7:0] next_host_wake_route_irq;
  logic [7:0] next_core_wake_route_enable;
  logic [7:0] next_wake_control1;
  logic [N_DEV-1:0] next_dev_wake_en;
  logic [7:0] next_rdata;
  wesr_pkg::wesr_out_t next_outs;

  // ---------------------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------------------
  logic ring1_edge;
  logic ring2_edge;
  logic irq_any;
  logic irq_edge;

  wesr_sync_edge #(.FALLING(1'b1)) u_ring1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(modem_ring_in1_n_i),
    .edge_o(ring1_edge)
  );

  wesr_sync_edge #(.FALLING(1'b1)) u_ring2 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(modem_ring_in2_n_i),
    .edge_o(ring2_edge)
  );

  wesr_irq_combine #(.N_DEV(N_DEV)) u_irq (
    .dev_irq_i(dev_irq_i),
    .dev_wake_en_i(dev_wake_en),
    .irq_any_o(irq_any)
  );

  wesr_sync_edge #(.FALLING(1'b0)) u_irq_edge (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(irq_any),
    .edge_o(irq_edge) // RULE11
  );

  // ---------------------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------------------
  logic host_blocked;
  logic wr_host_sts;
  logic wr_core_sts;
  logic [7:0] hw_set;
  logic sw_host_set;
  logic sw_host_clr;
  logic sw_core_set;

  // Host-side accesses are dropped while main power is absent.
  assign host_blocked = reg_host_i & ~main_pwr_i; // RULE8
  assign wr_host_sts = reg_wr_i & ~host_blocked & (reg_addr_i == wesr_pkg::ADDR_HOST_STATUS);
  assign wr_core_sts = reg_wr_i & ~host_blocked & (reg_addr_i == wesr_pkg::ADDR_CORE_STATUS);

  // Hardware events; detection only advances on clock edges.
  always_comb begin
    hw_set = 8'h00; // RULE16
    hw_set[wesr_pkg::EV_RING1] = ring1_edge; // RULE14
    hw_set[wesr_pkg::EV_RING2] = ring2_edge; // RULE14
    hw_set[wesr_pkg::EV_MOD_IRQ] = irq_edge; // RULE13
  end

  // Host software event toggles on a write of 1; the core event only sets.
  assign sw_host_set = wr_host_sts & reg_wdata_i[wesr_pkg::EV_SW] &
                       ~host_wake_status0[wesr_pkg::EV_SW]; // RULE7
  assign sw_host_clr = wr_host_sts & reg_wdata_i[wesr_pkg::EV_SW] &
                       host_wake_status0[wesr_pkg::EV_SW]; // RULE7
  assign sw_core_set = wake_control1[wesr_pkg::CTL_SW_CORE_MODE] ?
                       (wr_host_sts & reg_wdata_i[wesr_pkg::EV_SW]) : sw_host_set; // RULE9

  // ---------------------------------------------------------------------------
  // Status and configuration next values
  // ---------------------------------------------------------------------------
  logic [7:0] host_clr;
  logic [7:0] core_clr;

  always_comb begin
    host_clr = wr_host_sts ? reg_wdata_i : 8'h00; // RULE3
    core_clr = wr_core_sts ? reg_wdata_i : 8'h00; // RULE10
    host_clr[wesr_pkg::EV_SW] = sw_host_clr;
    next_host_wake_status0 = host_wake_status0 & ~host_clr;
    next_core_wake_status0 = core_wake_status0 & ~core_clr;
    // Sets win over clears in the same cycle.
    next_host_wake_status0 = (next_host_wake_status0 | hw_set) & wesr_pkg::EV_IMPL; // RULE1
    next_core_wake_status0 = (next_core_wake_status0 | hw_set) & wesr_pkg::EV_IMPL; // RULE1
    next_host_wake_status0[wesr_pkg::EV_SW] = next_host_wake_status0[wesr_pkg::EV_SW] |
                                              sw_host_set; // RULE6
    next_core_wake_status0[wesr_pkg::EV_SW] = next_core_wake_status0[wesr_pkg::EV_SW] |
                                              sw_core_set; // RULE6
    next_host_wake_route_pwr = host_wake_route_pwr;
    next_host_wake_route_smi = host_wake_route_smi;
    next_host_wake_route_irq = host_wake_route_irq;
    next_core_wake_route_enable = core_wake_route_enable;
    next_wake_control1 = wake_control1;
    next_dev_wake_en = dev_wake_en;
    if (reg_wr_i && !host_blocked) begin
      case (reg_addr_i)
        wesr_pkg::ADDR_HOST_ROUTE_PWR: next_host_wake_route_pwr = reg_wdata_i; // RULE18
        wesr_pkg::ADDR_HOST_ROUTE_SMI: next_host_wake_route_smi = reg_wdata_i; // RULE18
        wesr_pkg::ADDR_HOST_ROUTE_IRQ: next_host_wake_route_irq = reg_wdata_i; // RULE18
        wesr_pkg::ADDR_CORE_ROUTE: next_core_wake_route_enable = reg_wdata_i; // RULE5
        wesr_pkg::ADDR_CONTROL1: next_wake_control1 = reg_wdata_i;
        wesr_pkg::ADDR_DEV_WAKE_EN: begin
          for (int i = 0; i < N_DEV; i++) begin
            next_dev_wake_en[i] = reg_wdata_i[wesr_pkg::DEV_IRQ_WAKE_BIT] ?
                                  reg_wdata_i[i] : 1'b0; // RULE12
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs and read data
  // ---------------------------------------------------------------------------
  always_comb begin
    // Outputs follow status AND enable, so they hold until cleared or masked.
    next_outs.power_up_request = |(next_host_wake_status0 & next_host_wake_route_pwr); // RULE2
    next_outs.smi = |(next_host_wake_status0 & next_host_wake_route_smi); // RULE4
    next_outs.host_irq = |(next_host_wake_status0 & next_host_wake_route_irq); // RULE19
    next_outs.core_wake_interrupt =
      |(next_core_wake_status0 & next_core_wake_route_enable); // RULE20
    next_rdata = 8'h00;
    if (reg_rd_i && !host_blocked) begin
      case (reg_addr_i)
        wesr_pkg::ADDR_HOST_STATUS: next_rdata = host_wake_status0;
        wesr_pkg::ADDR_HOST_ROUTE_PWR: next_rdata = host_wake_route_pwr;
        wesr_pkg::ADDR_HOST_ROUTE_SMI: next_rdata = host_wake_route_smi;
        wesr_pkg::ADDR_HOST_ROUTE_IRQ: next_rdata = host_wake_route_irq;
        wesr_pkg::ADDR_CORE_STATUS: next_rdata = core_wake_status0;
        wesr_pkg::ADDR_CORE_ROUTE: next_rdata = core_wake_route_enable;
        wesr_pkg::ADDR_CONTROL1: next_rdata = wake_control1;
        wesr_pkg::ADDR_DEV_WAKE_EN: next_rdata = 8'(dev_wake_en);
        wesr_pkg::ADDR_PIN_LEVELS: next_rdata = {5'h00, irq_any, modem_ring_in2_n_i,
                                                 modem_ring_in1_n_i};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_wake_status0 <= wesr_pkg::EV_RST;
      core_wake_status0 <= wesr_pkg::EV_RST;
      host_wake_route_pwr <= wesr_pkg::EV_RST;
      host_wake_route_smi <= wesr_pkg::EV_RST;
      host_wake_route_irq <= wesr_pkg::EV_RST;
      core_wake_route_enable <= wesr_pkg::EV_RST;
      wake_control1 <= wesr_pkg::CTL_RST;
      dev_wake_en <= '0;
      rdata <= 8'h00;
      outs <= '0;
    end else begin
      host_wake_status0 <= next_host_wake_status0;
      core_wake_status0 <= next_core_wake_status0;
      host_wake_route_pwr <= next_host_wake_route_pwr;
      host_wake_route_smi <= next_host_wake_route_smi;
      host_wake_route_irq <= next_host_wake_route_irq;
      core_wake_route_enable <= next_core_wake_route_enable;
      wake_control1 <= next_wake_control1;
      dev_wake_en <= next_dev_wake_en;
      rdata <= next_rdata;
      outs <= next_outs;
    end
  end

  assign reg_rdata_o = rdata;
  assign power_up_request_o = outs.power_up_request; // RULE15
  assign smi_o = outs.smi; // RULE15
  assign host_irq_o = outs.host_irq; // RULE15
  assign core_wake_interrupt_o = outs.core_wake_interrupt; // RULE15

endmodule // wesr_wake_controller

// >>> wesr_wake_controller_checker.sv
// Port checker of the wake controller, bound onto wesr_wake_controller.
// Assumes the register map of wesr_pkg; shadows track accepted register writes.
`timescale 1ns/1ps
module wesr_wake_controller_checker #(
  parameter int N_DEV = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_host_i,
  input wire logic [7:0] reg_rdata_o,
  // Power and events
  input wire logic main_pwr_i,
  input wire logic modem_ring_in1_n_i,
  input wire logic modem_ring_in2_n_i,
  input wire logic [N_DEV-1:0] dev_irq_i,
  // Output events
  input wire logic power_up_request_o,
  input wire logic smi_o,
  input wire logic host_irq_o,
  input wire logic core_wake_interrupt_o
);
  logic ok, sw_h, sw_c, mode;
  logic [7:0] en_p, en_s, en_c;
  logic [N_DEV-1:0] dev_en;
  assign ok = reg_wr_i && (!reg_host_i || main_pwr_i);
  // Shadows of the power, SMI and core routing, mode, software-event and device-enable bits.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {sw_h, sw_c, mode, en_p, en_s, en_c, dev_en} <= '0;
    end else if (ok) begin
      case (reg_addr_i)
        wesr_pkg::ADDR_HOST_STATUS: begin
          sw_h <= sw_h ^ reg_wdata_i[0];
          if (reg_wdata_i[0] && (mode || !sw_h)) sw_c <= 1'b1;
        end
        wesr_pkg::ADDR_CORE_STATUS: if (reg_wdata_i[0]) sw_c <= 1'b0;
        wesr_pkg::ADDR_HOST_ROUTE_PWR: en_p <= reg_wdata_i;
        wesr_pkg::ADDR_HOST_ROUTE_SMI: en_s <= reg_wdata_i;
        wesr_pkg::ADDR_CORE_ROUTE: en_c <= reg_wdata_i;
        wesr_pkg::ADDR_CONTROL1: mode <= reg_wdata_i[0];
        wesr_pkg::ADDR_DEV_WAKE_EN: begin
          dev_en <= reg_wdata_i[wesr_pkg::DEV_IRQ_WAKE_BIT] ? reg_wdata_i[N_DEV-1:0] : '0;
        end
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_pwr_sw; sw_h && en_p[0] |-> power_up_request_o; endproperty
  a_pwr_sw: assert property (p_pwr_sw) else $error("power request low");
  property p_smi_sw; sw_h && en_s[0] |-> smi_o; endproperty
  a_smi_sw: assert property (p_smi_sw) else $error("smi low");
  property p_core_sw; sw_c && en_c[0] |-> core_wake_interrupt_o; endproperty
  a_core_sw: assert property (p_core_sw) else $error("core interrupt low");
  property p_pwr_off; (en_p & wesr_pkg::EV_IMPL) == 8'h00 |-> !power_up_request_o; endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("power request unrouted");
  property p_core_mask; (en_c & wesr_pkg::EV_IMPL) == 8'h00 |-> !core_wake_interrupt_o;
  endproperty
  a_core_mask: assert property (p_core_mask) else $error("core interrupt masked");
  property p_rd_sw;
    $past(reg_rd_i && reg_addr_i == wesr_pkg::ADDR_HOST_STATUS && (!reg_host_i || main_pwr_i))
      |-> reg_rdata_o[0] == $past(sw_h);
  endproperty
  a_rd_sw: assert property (p_rd_sw) else $error("software bit read wrong");
  property p_refuse; $past(reg_rd_i && reg_host_i && !main_pwr_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("host read without power");
  property p_hold; $fell(power_up_request_o) |-> $past(ok); endproperty
  a_hold: assert property (p_hold) else $error("power request dropped");
  property p_ring; $fell(modem_ring_in1_n_i) && en_p[1]
    |-> ##[1:6] (power_up_request_o || !en_p[1]); endproperty
  a_ring: assert property (p_ring) else $error("ring not seen");
  property p_irq; $rose(dev_irq_i[0]) && dev_en == N_DEV'(1) && en_p[7]
    |-> ##[1:6] (power_up_request_o || !en_p[7]); endproperty
  a_irq: assert property (p_irq) else $error("module irq not seen");
endmodule // wesr_wake_controller_checker

bind wesr_wake_controller wesr_wake_controller_checker #(.N_DEV(N_DEV)) u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_host_i(reg_host_i),
  .reg_rdata_o(reg_rdata_o), .main_pwr_i(main_pwr_i), .dev_irq_i(dev_irq_i),
  .modem_ring_in1_n_i(modem_ring_in1_n_i), .modem_ring_in2_n_i(modem_ring_in2_n_i),
  .power_up_request_o(power_up_request_o), .smi_o(smi_o), .host_irq_o(host_irq_o),
  .core_wake_interrupt_o(core_wake_interrupt_o));

// >>> wesr_event_src.sv
// Model of the event sources: two modem ring lines and the device interrupt lines.
// Assumes the bench calls its tasks; ring lines idle high as with a pull-up.
`timescale 1ns/1ps
module wesr_event_src #(
  parameter int N_DEV = 3
) (
  // Clock
  input wire logic clk_i,
  // Event lines
  output logic modem_ring_in1_n_o,
  output logic modem_ring_in2_n_o,
  output logic [N_DEV-1:0] dev_irq_o
);
  initial begin
    modem_ring_in1_n_o = 1'b1;
    modem_ring_in2_n_o = 1'b1;
    dev_irq_o = '0;
  end
  // A ring pulls one line low for four cycles, then releases it high.
  task automatic ring(input int k);
    @(posedge clk_i);
    if (k == 1) modem_ring_in1_n_o <= 1'b0;
    else modem_ring_in2_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    modem_ring_in1_n_o <= 1'b1;
    modem_ring_in2_n_o <= 1'b1;
  endtask
  task automatic irq(input int i, input logic v);
    @(posedge clk_i);
    dev_irq_o[i] <= v;
  endtask
endmodule // wesr_event_src

// >>> wesr_wake_controller_tb.sv
// Self-checking bench of the wake controller.
// Assumes the event source model and the bound port checker.
`timescale 1ns/1ps
module wesr_wake_controller_tb;
  localparam logic [3:0] A_HS = wesr_pkg::ADDR_HOST_STATUS;
  localparam logic [3:0] A_RP = wesr_pkg::ADDR_HOST_ROUTE_PWR;
  localparam logic [3:0] A_CS = wesr_pkg::ADDR_CORE_STATUS;
  localparam logic [3:0] A_C1 = wesr_pkg::ADDR_CONTROL1;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic main_pwr_i = 1'b1;
  logic host = 1'b0;
  wesr_pkg::wesr_bus_t bus = '0;
  wesr_pkg::wesr_out_t outs;
  logic [7:0] rdata;
  logic ring1_n, ring2_n;
  logic [2:0] dev_irq;
  int n_fail = 0;
  int num_checks = 0;
  always #10 clk_i = ~clk_i;
  wesr_event_src #(.N_DEV(3)) u_src (.clk_i(clk_i), .modem_ring_in1_n_o(ring1_n),
    .modem_ring_in2_n_o(ring2_n), .dev_irq_o(dev_irq));
  wesr_wake_controller #(.N_DEV(3)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(bus.addr), .reg_wdata_i(bus.wdata), .reg_wr_i(bus.wr), .reg_rd_i(bus.rd),
    .reg_host_i(host), .reg_rdata_o(rdata), .main_pwr_i(main_pwr_i),
    .modem_ring_in1_n_i(ring1_n), .modem_ring_in2_n_i(ring2_n), .dev_irq_i(dev_irq),
    .power_up_request_o(outs.power_up_request), .smi_o(outs.smi),
    .host_irq_o(outs.host_irq), .core_wake_interrupt_o(outs.core_wake_interrupt));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic h = 1'b0);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    host <= h;
    @(posedge clk_i);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic h = 1'b0);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    host <= h;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic chk_out(input logic [3:0] e);
    check({4'h0, outs}, {4'h0, e});
  endtask
  task automatic wait_pwr();
    int i;
    #1;
    for (i = 0; i < 20 && outs.power_up_request !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (outs.power_up_request !== 1'b1) begin
      check(8'h00, 8'h01);
      final_report();
    end
  endtask
  task automatic t_defaults();
    chk_out(4'h0);
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
    rd(4'hf, 8'h00);
    rd(wesr_pkg::ADDR_PIN_LEVELS, 8'h03);
  endtask
  task automatic t_sw(input logic m);
    for (int a = 1; a < 4; a++) wr(4'(a), 8'h01);
    wr(wesr_pkg::ADDR_CORE_ROUTE, 8'h01);
    wr(A_C1, {7'h0, m});
    chk_out(4'h0);
    wr(A_HS, 8'h01, 1'b1);
    chk_out(4'hf);
    rd(A_CS, 8'h01);
    wr(A_HS, 8'h00, 1'b1);
    rd(A_HS, 8'h01, 1'b1);
    wr(A_CS, 8'h01);
    chk_out(4'he);
    wr(A_HS, 8'h01);
    chk_out({3'h0, m});
    rd(A_CS, {7'h0, m});
    wr(A_CS, 8'h01);
  endtask
  task automatic t_power();
    @(posedge clk_i);
    main_pwr_i <= 1'b0;
    wr(A_HS, 8'h01, 1'b1);
    rd(A_HS, 8'h00);
    wr(A_HS, 8'h01);
    rd(A_HS, 8'h00, 1'b1);
    rd(A_HS, 8'h01);
    wr(A_HS, 8'h01);
    wr(A_CS, 8'h01);
    @(posedge clk_i);
    main_pwr_i <= 1'b1;
  endtask
  task automatic t_ring();
    wr(A_RP, 8'h86);
    wr(wesr_pkg::ADDR_HOST_ROUTE_SMI, 8'h00);
    wr(wesr_pkg::ADDR_HOST_ROUTE_IRQ, 8'h00);
    wr(wesr_pkg::ADDR_CORE_ROUTE, 8'h86);
    u_src.ring(1);
    wait_pwr();
    rd(A_HS, 8'h02);
    rd(A_CS, 8'h02);
    wr(A_RP, 8'h00);
    chk_out(4'h1);
    rd(A_HS, 8'h02);
    wr(A_RP, 8'h86);
    chk_out(4'h9);
    wr(A_HS, 8'h02);
    chk_out(4'h1);
    wr(A_CS, 8'h02);
    chk_out(4'h0);
    repeat (10) @(posedge clk_i);
    rd(A_HS, 8'h00);
    u_src.ring(2);
    wait_pwr();
    rd(A_CS, 8'h04);
    wr(A_HS, 8'h04);
    wr(A_CS, 8'h04);
  endtask
  task automatic t_irq();
    wr(wesr_pkg::ADDR_DEV_WAKE_EN, 8'h11);
    u_src.irq(1, 1'b1);
    repeat (8) @(posedge clk_i);
    rd(A_HS, 8'h00);
    u_src.irq(0, 1'b1);
    wait_pwr();
    rd(A_HS, 8'h80);
    repeat (10) @(posedge clk_i);
    chk_out(4'h9);
    wr(A_HS, 8'h80);
    wr(A_CS, 8'h80);
    repeat (8) @(posedge clk_i);
    rd(A_HS, 8'h00);
    u_src.irq(0, 1'b0);
    u_src.irq(1, 1'b0);
    wr(wesr_pkg::ADDR_DEV_WAKE_EN, 8'h01);
    u_src.irq(0, 1'b1);
    repeat (8) @(posedge clk_i);
    rd(A_HS, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_defaults();
    t_sw(1'b0);
    t_sw(1'b1);
    wr(A_C1, 8'h00);
    t_power();
    t_ring();
    t_irq();
    final_report();
  end
endmodule // wesr_wake_controller_tb
